// ===== rtl/rio_port.sv
// relay output and isolated input port with two edge interrupts
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
module rio_port
(
   // clocking and resets
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        powerOnRst,
   input  wire logic        clkEn,
   input  wire logic        hot_reset_retain_strap,
   // byte register access
   input  wire logic [1:0]  regAddr,
   input  wire logic        regWrite,
   input  wire logic [7:0]  regWdata,
   output logic      [7:0]  regRdata,
   // interrupt control bits
   input  wire logic        irqRiseLow,
   input  wire logic        irqRiseHigh,
   input  wire logic        irqEnLow,
   input  wire logic        irqEnHigh,
   input  wire logic        irqClrLow,
   input  wire logic        irqClrHigh,
   output logic      [1:0]  irqFlags,
   output logic             irqOut,
   // field side
   input  wire logic [15:0] isolated_input,
   output logic      [15:0] relayDrive
);
   import rio_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // state registers and the two per-channel edge pulses
   logic [15:0] relay_q;
   logic [15:0] sync1_q;
   logic [15:0] sync2_q;
   logic [1:0]  flag_q;
   logic [7:0]  rdata_q;
   logic [1:0]  edgeHit;

   // one-hot offset decode, shared by the write strobes and the readback mux;
   // all four offsets decode, so a write to an input offset is simply dropped
   function automatic logic [3:0] byteSelect(input logic [1:0] addr);
      byteSelect = 4'h0;
      byteSelect[addr] = 1'b1;
   endfunction : byteSelect

   wire [3:0] addrHit = byteSelect(regAddr);
   // hot reset clears relays only when the strap does not ask to retain
   wire relayClear = powerOnRst | (sys_rst & ~hot_reset_retain_strap);
   wire wrLo = regWrite & addrHit[OFF_RELAY_LO];
   wire wrHi = regWrite & addrHit[OFF_RELAY_HI];

   // relay bits; power reset always wins, 1 energises coil
   always_ff @(posedge clk)
   begin
      if (relayClear)
         relay_q <= RELAY_RESET;
      else if (clkEn)
      begin
         if (wrLo)
            relay_q[7:0] <= regWdata;
         if (wrHi)
            relay_q[15:8] <= regWdata;
      end
   end
   // straight from the flops, so a coil never sees a decode glitch
   assign relayDrive = relay_q;

   ////////////////////////////////////////////////////////////////////////////
   // either applied polarity reaches this port already folded to one level
   // two-stage synchroniser; first stage feeds only the second
   // clearing both stages on hot reset costs two edges of blindness afterwards
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         sync1_q <= 16'h0000;
         sync2_q <= 16'h0000;
      end
      else if (clkEn)
      begin
         sync1_q <= isolated_input;
         sync2_q <= sync1_q;
      end
   end

   wire [7:0] rdMux = addrHit[OFF_RELAY_LO] ? relay_q[7:0]  :
                      addrHit[OFF_RELAY_HI] ? relay_q[15:8] :
                      addrHit[OFF_INPUT_LO] ? sync2_q[7:0]  : sync2_q[15:8];
   // registered so the host never sees the mux settle after an offset change
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         rdata_q <= 8'h00;
      else if (clkEn)
         rdata_q <= rdMux;
   end
   assign regRdata = rdata_q;

   ////////////////////////////////////////////////////////////////////////////
   // edge detectors on the two interrupt-capable channels
   wire [1:0] srcLevel = {sync2_q[IRQ_CH_HIGH], sync2_q[IRQ_CH_LOW]};
   wire [1:0] srcRise  = {irqRiseHigh, irqRiseLow};
   wire [1:0] srcEn    = {irqEnHigh, irqEnLow};
   wire [1:0] srcClr   = {irqClrHigh, irqClrLow};
   // one detector per interrupt-capable channel
   genvar g;
   generate
      for (g = 0; g < 2; g++)
      begin : gEdge
         rio_edge_detect uEdge
         (
            .clk       (clk),
            .sys_rst   (sys_rst),
            .clkEn     (clkEn),
            .level     (srcLevel[g]),
            .risingSel (srcRise[g]),
            .edgePulse (edgeHit[g])
         );
      end
   endgenerate

   // sticky flags; an edge only latches when enabled, set beats clear
   wire [1:0] flagSet = edgeHit & srcEn;
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         flag_q <= FLAG_RESET;
      else if (clkEn)
         flag_q <= flagSet | (flag_q & ~srcClr);
   end
   // flags stay visible to the host even while their channel is disabled
   assign irqFlags = flag_q;
   // interrupt while an enabled flag stands
   assign irqOut = |(flag_q & srcEn);

   ////////////////////////////////////////////////////////////////////////////
   // checks share the bus clock and stand down during hot reset unless told otherwise
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   // a write at offset zero lands in the low relay byte
   chk_relay_write_lo: assert property (
      clkEn && wrLo && !powerOnRst |=> relay_q[7:0] == $past(regWdata))
      else $error("relay low byte not written");
   // a write at offset one lands in the high relay byte
   chk_relay_write_hi: assert property (
      clkEn && wrHi && !powerOnRst |=> relay_q[15:8] == $past(regWdata))
      else $error("relay high byte not written");
   // relay bits move only on an accepted write or a clear
   chk_relay_hold: assert property (
      !relayClear && !(clkEn && (wrLo || wrHi)) |=> relay_q == $past(relay_q))
      else $error("relay bits changed without a write");
   // power reset always de-energises every relay
   chk_power_clear: assert property (
      powerOnRst |=> relay_q == 16'h0000)
      else $error("power reset left relays set");
   // strap set: hot reset keeps the relay bits
   chk_strap_retain: assert property (
      disable iff (powerOnRst)
      sys_rst && hot_reset_retain_strap && !regWrite |=> relay_q == $past(relay_q))
      else $error("hot reset lost retained relays");
   // strap clear: hot reset empties the relay bits
   chk_strap_clear: assert property (
      disable iff (1'b0)
      sys_rst && !hot_reset_retain_strap |=> relay_q == 16'h0000)
      else $error("hot reset left relays set");

   ////////////////////////////////////////////////////////////////////////////
   // two enabled edges carry an input level onto the read path
   chk_input_sync_path: assert property (
      clkEn ##1 clkEn |=> sync2_q == $past(isolated_input, 2))
      else $error("input sync latency wrong");
   // the high input byte is returned one edge after its offset
   chk_input_readback: assert property (
      clkEn && regAddr == OFF_INPUT_HI |=> regRdata == $past(sync2_q[15:8]))
      else $error("input readback wrong");

   ////////////////////////////////////////////////////////////////////////////
   // an enabled selected edge latches the low flag
   chk_flag_set_edge: assert property (
      clkEn && edgeHit[0] && irqEnLow |=> flag_q[0])
      else $error("low flag not set");
   // a clear with no competing edge empties the low flag
   chk_flag_clear: assert property (
      clkEn && irqClrLow && !(edgeHit[0] && irqEnLow) |=> !flag_q[0])
      else $error("low flag not cleared");
   // a disabled high channel never raises its flag
   chk_flag_disabled: assert property (
      clkEn && !irqEnHigh && !flag_q[1] |=> !flag_q[1])
      else $error("disabled high flag set");
   // interrupt stands exactly while an enabled flag stands
   chk_irq_level: assert property (
      irqOut == ((flag_q[0] && irqEnLow) || (flag_q[1] && irqEnHigh)))
      else $error("irq level wrong");
   // rising polarity turns a rise of channel zero into an edge
   chk_edge_polarity: assert property (
      clkEn && irqRiseLow && $rose(sync2_q[IRQ_CH_LOW]) |-> edgeHit[0])
      else $error("rising edge missed");

   // main scenarios: each channel interrupting, a dropped edge, a high byte write
   cov_irq_low: cover property (flagSet[0] ##1 irqOut);
   cov_irq_high: cover property (flagSet[1] ##1 irqOut);
   cov_disabled_edge: cover property (clkEn && edgeHit[0] && !irqEnLow);
   cov_relay_hi_write: cover property (clkEn && wrHi);
endmodule : rio_port

// ===== rtl/rio_pkg.sv
// constants shared by the relay output / isolated input port
package rio_pkg;
   localparam int RELAY_COUNT   = 16;
   localparam int INPUT_COUNT   = 16;
   localparam int SYNC_STAGES   = 2;
   // byte offsets of the host-visible ports
   localparam logic [1:0] OFF_RELAY_LO = 2'h0;
   localparam logic [1:0] OFF_RELAY_HI = 2'h1;
   localparam logic [1:0] OFF_INPUT_LO = 2'h2;
   localparam logic [1:0] OFF_INPUT_HI = 2'h3;
   // interrupt-capable channel positions
   localparam int IRQ_CH_LOW    = 0;
   localparam int IRQ_CH_HIGH   = 8;
   // reset values
   localparam logic [15:0] RELAY_RESET = 16'h0000;
   localparam logic [1:0]  FLAG_RESET  = 2'h0;
endpackage : rio_pkg

// ===== rtl/rio_edge_detect.sv
// edge detector with polarity select for one synchronised input
`timescale 1ns/1ns
module rio_edge_detect
(
   // clocking
   input  wire logic clk,
   input  wire logic sys_rst,
   input  wire logic clkEn,
   // input level and polarity
   input  wire logic level,
   input  wire logic risingSel,
   // detected edge pulse
   output logic      edgePulse
);
   logic prev_q;
   // previous sample; reset to current-safe zero so no spurious edge at release of a low line
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         prev_q <= 1'b0;
      else if (clkEn)
         prev_q <= level;
   end
   wire riseSeen = level & ~prev_q;
   wire fallSeen = ~level & prev_q;
   assign edgePulse = clkEn & ~sys_rst & (risingSel ? riseSeen : fallSeen);
endmodule : rio_edge_detect

// ===== verification/rio_field_model.sv
// field side model: isolator stage between field wiring and the port
`timescale 1ns/1ns
module rio_field_model
#(
   parameter int DLY = 3
)
(
   // clocking
   input  wire logic        clk,
   // field wiring and isolated levels
   input  wire logic [15:0] fieldLevel,
   output logic      [15:0] isoLevel
);
   logic [15:0] pipe [DLY];
   // level only, either polarity already folded into fieldLevel
   always @(posedge clk)
   begin
      pipe[0] <= fieldLevel;
      for (int i = 1; i < DLY; i++) pipe[i] <= pipe[i-1];
   end
   assign isoLevel = pipe[DLY-1];
endmodule : rio_field_model

// ===== verification/rio_port_tb_top.sv
// self-checking bench for the relay and isolated input port
`timescale 1ns/1ns
module rio_port_tb_top;
   import rio_pkg::*;
   logic        clk, sysRst, porRst, strap, regWrite, rl, rh, el, eh, cl, ch, irq, en;
   logic [1:0]  regAddr, flags;
   logic [7:0]  wdata, rdata;
   logic [15:0] field, iso, relays;
   int          mismatches, check_count;
   rio_port i_dut (.clk(clk), .sys_rst(sysRst), .powerOnRst(porRst), .clkEn(en),
      .hot_reset_retain_strap(strap), .regAddr(regAddr), .regWrite(regWrite),
      .regWdata(wdata), .regRdata(rdata), .irqRiseLow(rl), .irqRiseHigh(rh),
      .irqEnLow(el), .irqEnHigh(eh), .irqClrLow(cl), .irqClrHigh(ch), .irqFlags(flags),
      .irqOut(irq), .isolated_input(iso), .relayDrive(relays));
   rio_field_model i_field (.clk(clk), .fieldLevel(field), .isoLevel(iso));
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("FAIL %0t seen %h exp %h", $time, seen, exp);
      end
   endtask : check
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      regAddr = a;
      wdata = d;
      regWrite = 1'b1;
      tick(1);
      // drop the strobe and let an edge pass, so a following call never re-raises it at once
      regWrite = 1'b0;
      tick(1);
   endtask : wr
   task automatic rd(input logic [1:0] a, input logic [7:0] exp);
      regAddr = a;
      tick(2);
      check(16'(rdata), 16'(exp));
   endtask : rd
   task automatic pulse(input bit por);
      if (por)
         porRst = 1'b1;
      else
         sysRst = 1'b1;
      tick(1);
      porRst = 1'b0;
      sysRst = 1'b0;
   endtask : pulse
   task automatic t_relay;
      check(relays, RELAY_RESET);
      wr(OFF_RELAY_LO, 8'hA5); wr(OFF_RELAY_HI, 8'h3C); wr(OFF_INPUT_LO, 8'hFF);
      check(relays, 16'h3CA5);
      // contacts settle after the coil drive; a host waits before trusting them
      rd(OFF_RELAY_LO, 8'hA5);
      rd(OFF_RELAY_HI, 8'h3C);
      $display("test relay done");
   endtask : t_relay
   task automatic t_input;
      field = 16'h8001; tick(8);
      rd(OFF_INPUT_LO, 8'h01);
      rd(OFF_INPUT_HI, 8'h80);
      $display("test input done");
   endtask : t_input
   task automatic t_irq;
      for (int p = 0; p < 2; p++)
      begin
         rl = p[0];
         rh = p[0];
         el = 1'b1;
         eh = 1'b1;
         field = p[0] ? 16'h0000 : 16'h0101;
         tick(8);
         cl = 1'b1;
         ch = 1'b1;
         tick(1);
         cl = 1'b0;
         ch = 1'b0;
         field[1] = ~field[1];
         tick(8);
         check(16'(flags), 16'h0);
         field = p[0] ? 16'h0101 : 16'h0000;
         tick(8);
         check(16'({flags, irq}), 16'h7);
         el = 1'b0;
         eh = 1'b0;
         tick(1);
         check(16'(irq), 16'h0);
         check(16'(flags), 16'h3);
         cl = 1'b1;
         ch = 1'b1;
         tick(1);
         cl = 1'b0;
         ch = 1'b0;
         check(16'(flags), 16'h0);
         // toggle both ways so the selected polarity reaches the disabled channels
         field = ~field;
         tick(8);
         field = ~field;
         tick(8);
         check(16'(flags), 16'h0);
      end
      $display("test irq done");
   endtask : t_irq
   task automatic t_hot;
      strap = 1'b1; wr(OFF_RELAY_LO, 8'h5A); pulse(1'b0);
      check(relays, 16'h3C5A);
      strap = 1'b0; pulse(1'b0);
      check(relays, RELAY_RESET);
      strap = 1'b1; wr(OFF_RELAY_HI, 8'hFF); pulse(1'b1);
      check(relays, RELAY_RESET);
      $display("test hot reset done");
   endtask : t_hot
   task automatic t_freeze;
      // clock enable low: a write must not land until the enable returns
      en = 1'b0;
      wr(OFF_RELAY_LO, 8'h77);
      check(relays, RELAY_RESET);
      en = 1'b1;
      wr(OFF_RELAY_LO, 8'h77);
      check(relays, 16'h0077);
      $display("test freeze done");
   endtask : t_freeze
   task automatic results;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : results
   // watchdog well past the 124 or so cycles the tests need
   initial
   begin
      #200000;
      mismatches++;
      results();
   end
   initial
   begin
      {sysRst, porRst, strap, regWrite, rl, rh, el, eh, cl, ch} = 10'h300;
      regAddr = 2'h0;
      wdata = 8'h00;
      field = 16'h0000;
      en = 1'b1;
      tick(5);
      sysRst = 1'b0;
      porRst = 1'b0;
      t_relay();
      t_input();
      t_irq();
      t_hot();
      t_freeze();
      results();
   end
endmodule : rio_port_tb_top
